// ==== verilog/ssr_pkg.sv ====
// Constants, types and reset values for the strip readout sparsifier.
// Operation
// - One hit channel per strip; its discriminator feeds the readout.
// - Each hit gets a small amplitude code from pulse width conversion.
// - Hits wait in storage for a trigger, then leave with their stamp.
// - Exactly one output word per strip hit that is read out.
// - Serial programming link loads commands and data into registers.
// - Registers hold bias settings, output rate and injection pattern.
// - Each strip owns its slots; different stamps take separate slots.
// - On trigger only hits whose stamp equals the trigger stamp go out.
// - Four equal sections; each sparsifier encodes a hit per cycle.
// - A FIFO after each sparsifier holds encoded hits until merging.
// - Concentrator merges four section streams keeping stamp order.
// - Output drives one to four serial lines on the output timing.
// - Hit word: strip, stamp, valid, amplitude, chip, spare fields.
// - Stamps advance on one common stamp clock, once per 50 ns system clock cycle.
// - Any strip can be disabled digitally and then yields no hits.
package ssr_pkg;
  localparam int NUM_STRIPS  = 128;
  localparam int NUM_SECT    = 4;
  localparam int SECT_STRIPS = NUM_STRIPS / NUM_SECT;
  localparam int SECT_W      = 5;
  localparam int SLOTS       = 2;
  localparam int STRIP_W     = 7;
  localparam int STAMP_W     = 9;
  localparam int CHIP_W      = 4;
  localparam int AMP_W       = 4;
  localparam int SPARE_W     = 2;
  localparam int CLK_MHZ     = 20;
  localparam int STAMP_NS    = 30;
  localparam int STAMP_RAW   = (STAMP_NS * CLK_MHZ + 999) / 1000;
  localparam int STAMP_CYC   = (STAMP_RAW < 1) ? 1 : STAMP_RAW;
  localparam int TRIG_GAP_NS = 70;
  localparam int TRIG_GAP_CYC = (TRIG_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int TRIGQ_DEPTH = 4;
  localparam int FIFO_DEPTH  = 8;
  localparam int SER_BITS    = 28;
  // Configuration frame: read flag, address, data byte
  localparam int CFG_FRAME   = 16;
  localparam int NUM_CFG     = 32;
  localparam int NUM_BIAS    = 4;
  localparam int REG_BIAS    = 0;
  localparam int REG_OUT     = 4;
  localparam int REG_INJ     = 5;
  localparam int REG_CHIP    = 6;
  localparam int REG_LAT     = 7;
  localparam int REG_MASK    = 16;
  localparam int OUT_LANE_LSB = 0;
  localparam int OUT_DIV_LSB = 2;
  localparam logic [7:0] BIAS_RST = 8'h80;
  localparam logic [7:0] OUT_RST  = 8'h03;
  localparam logic [7:0] INJ_RST  = 8'h00;
  localparam logic [7:0] CHIP_RST = 8'h00;
  // Near 11.7 us of latency in 50 ns stamps
  localparam logic [7:0] LAT_RST  = 8'he9;
  localparam logic [7:0] MASK_RST = 8'h00;

  typedef struct packed {
    logic [SPARE_W-1:0] spare;
    logic [CHIP_W-1:0]  chip;
    logic [AMP_W-1:0]   amp;
    logic               valid;
    logic [STAMP_W-1:0] stamp;
    logic [STRIP_W-1:0] strip;
  } ssr_hit_s;
  localparam int HIT_W = $bits(ssr_hit_s);

  typedef struct packed {
    logic               v;
    logic               sel;
    logic [STAMP_W-1:0] stamp;
    logic [AMP_W-1:0]   amp;
  } ssr_slot_s;

  typedef struct packed {
    logic               vld;
    logic [STAMP_W-1:0] stamp;
  } ssr_trig_s;

  typedef struct packed {
    logic csn;
    logic sdi;
    logic sclk;
  } ssr_cfg_in_s;

  typedef struct packed {
    logic [3:0] data;
    logic       frame;
    logic       strobe;
  } ssr_ser_s;

  function automatic logic [7:0] cfg_rst(input int i);
    if (i < REG_OUT) return BIAS_RST;
    if (i == REG_OUT) return OUT_RST;
    if (i == REG_INJ) return INJ_RST;
    if (i == REG_CHIP) return CHIP_RST;
    if (i == REG_LAT) return LAT_RST;
    return MASK_RST;
  endfunction
endpackage

// ==== verilog/ssr_fifo.sv ====
// Section FIFO with registered head word.
`timescale 1ns/10ps
module ssr_fifo #(
  parameter int W     = 27,
  parameter int DEPTH = 8
) (
  input  wire logic         sys_clk_i,
  input  wire logic         srst_i,
  input  wire logic         in_vld_i,
  output logic              in_rdy_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_vld_o,
  input  wire logic         out_rdy_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  wire           push = in_vld_i & in_rdy_o;
  wire           load = (cnt_q != '0) & (~out_vld_o | out_rdy_i);
  assign in_rdy_o = (cnt_q != (AW+1)'(DEPTH));

  always_ff @(posedge sys_clk_i)
  begin
    if (push)
      mem_q[wp_q] <= in_data_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      wp_q       <= '0;
      rp_q       <= '0;
      cnt_q      <= '0;
      out_vld_o  <= 1'b0;
      out_data_o <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (load)
      begin
        out_data_o <= mem_q[rp_q];
        rp_q       <= rp_q + 1'b1;
      end
      if (load)
        out_vld_o <= 1'b1;
      else if (out_rdy_i)
        out_vld_o <= 1'b0;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
    end
  end
endmodule // ssr_fifo

// ==== verilog/ssr_readout.sv ====
// Strip readout: conversion, slots, sparsifiers, concentrator, serializer.
`timescale 1ns/10ps
module ssr_readout (
  input  wire logic                                  sys_clk_i,
  input  wire logic                                  srst_i,
  input  wire logic [ssr_pkg::NUM_STRIPS-1:0]        disc_i,
  input  wire ssr_pkg::ssr_trig_s                    trig_i,
  input  wire ssr_pkg::ssr_cfg_in_s                  cfg_i,
  output logic                                       cfg_sdo_o,
  output logic [ssr_pkg::NUM_BIAS*8-1:0]             bias_dac_o,
  output logic [7:0]                                 inject_sel_o,
  output ssr_pkg::ssr_ser_s                          ser_o,
  output logic                                       trig_drop_o
);
  import ssr_pkg::*;

  logic [7:0]         cfg_q [NUM_CFG];
  logic [STAMP_W-1:0] stamp_q;
  logic [3:0]         sdiv_q;
  wire                stamp_en = (sdiv_q == 4'(STAMP_CYC - 1));
  wire [1:0]          lanes_m1 = cfg_q[REG_OUT][OUT_LANE_LSB +: 2];
  wire [3:0]          bit_div  = cfg_q[REG_OUT][OUT_DIV_LSB +: 4];
  wire [CHIP_W-1:0]   chip_id  = cfg_q[REG_CHIP][CHIP_W-1:0];
  wire [7:0]          lat_win  = cfg_q[REG_LAT];
  wire [NUM_STRIPS-1:0] dis;

  // Common stamp counter
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      sdiv_q  <= '0;
      stamp_q <= '0;
    end
    else
    begin
      sdiv_q <= stamp_en ? 4'h0 : sdiv_q + 4'h1;
      if (stamp_en)
        stamp_q <= stamp_q + 1'b1;
    end
  end

  // Configuration link, pins pass three flops
  logic [2:0] c1_q, c2_q, c3_q, cst_q;
  logic [3:0] bcnt_q;
  logic [6:0] sh_q;
  logic [7:0] cmd_q, rdsh_q;
  wire  [2:0] cst_n = (~(c2_q ^ c3_q) & c3_q) | ((c2_q ^ c3_q) & cst_q);
  wire        s_rise = cst_n[0] & ~cst_q[0];
  wire        s_fall = ~cst_n[0] & cst_q[0];
  wire        s_sdi  = cst_n[1];
  wire        s_csn  = cst_n[2];
  wire  [7:0] s_byte = {sh_q, s_sdi};
  wire  [4:0] cmd_addr = cmd_q[4:0];
  wire        cmd_rd   = cmd_q[7];
  wire        cfg_wr   = ~s_csn & s_rise & (bcnt_q == 4'hf) & ~cmd_rd;

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      c1_q <= 3'h4;
      c2_q <= 3'h4;
      c3_q <= 3'h4;
      cst_q <= 3'h4;
      bcnt_q <= '0;
      sh_q <= '0;
      cmd_q <= '0;
      rdsh_q <= '0;
      cfg_sdo_o <= 1'b0;
    end
    else
    begin
      c1_q  <= cfg_i;
      c2_q  <= c1_q;
      c3_q  <= c2_q;
      cst_q <= cst_n;
      if (s_csn)
        bcnt_q <= '0;
      else if (s_rise)
      begin
        sh_q   <= s_byte[6:0];
        bcnt_q <= bcnt_q + 4'h1;
        if (bcnt_q == 4'h7)
        begin
          cmd_q  <= s_byte;
          rdsh_q <= cfg_q[s_byte[4:0]];
        end
      end
      else if (s_fall & bcnt_q[3] & cmd_rd)
      begin
        cfg_sdo_o <= rdsh_q[7];
        rdsh_q    <= {rdsh_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    for (int r = 0; r < NUM_CFG; r++)
      if (srst_i)
        cfg_q[r] <= cfg_rst(r);
      else if (cfg_wr && cmd_addr == 5'(r))
        cfg_q[r] <= s_byte;
  end

  always_comb
  begin
    for (int b = 0; b < NUM_BIAS; b++)
      bias_dac_o[b*8 +: 8] = cfg_q[REG_BIAS + b];
  end
  assign inject_sel_o = cfg_q[REG_INJ];

  // Trigger stamp queue
  logic [STAMP_W-1:0] tq_q [TRIGQ_DEPTH];
  logic [1:0]         twp_q, trp_q;
  logic [2:0]         tcnt_q;
  logic [NUM_SECT-1:0] sreq;
  wire                tq_vld  = (tcnt_q != 3'h0);
  wire [STAMP_W-1:0]  head    = tq_q[trp_q];
  wire                trig_ok = trig_i.vld & (tcnt_q != 3'(TRIGQ_DEPTH));
  wire                tq_pop  = tq_vld & ~|sreq;

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      twp_q <= '0;
      trp_q <= '0;
      tcnt_q <= '0;
      trig_drop_o <= 1'b0;
    end
    else
    begin
      // Queue lets triggers arrive every cycle, well inside the spacing
      if (trig_ok)
      begin
        tq_q[twp_q] <= trig_i.stamp;
        twp_q <= twp_q + 2'h1;
      end
      if (tq_pop)
        trp_q <= trp_q + 2'h1;
      tcnt_q <= tcnt_q + 3'(trig_ok) - 3'(tq_pop);
      trig_drop_o <= trig_i.vld & ~trig_ok;
    end
  end

  // Per strip conversion and pre-trigger slots
  logic [SLOTS-1:0] match [NUM_STRIPS];
  logic [AMP_W-1:0] m_amp [NUM_STRIPS];
  logic [SECT_W-1:0] gidx [NUM_SECT];
  logic [NUM_SECT-1:0] spush;

  for (genvar i = 0; i < NUM_STRIPS; i++)
  begin : g_strip
    logic [2:0]         s_q;
    logic               lvl_q;
    logic [AMP_W-1:0]   cnt_q;
    logic [STAMP_W-1:0] st_q;
    ssr_slot_s          slot_q [SLOTS];
    logic [SLOTS-1:0]   wr, clr, ex, mk;
    assign dis[i] = cfg_q[REG_MASK + i/8][i%8];
    wire lvl_n   = (s_q[1] == s_q[2]) ? s_q[2] : lvl_q;
    wire hit_end = lvl_q & ~lvl_n & ~dis[i];
    wire clr_any = spush[i/SECT_STRIPS] &
                   (gidx[i/SECT_STRIPS] == SECT_W'(i % SECT_STRIPS));
    // Slot 0 first; when both slots busy the new hit is lost
    assign wr[0] = hit_end & ~slot_q[0].v;
    assign wr[1] = hit_end & slot_q[0].v & ~slot_q[1].v;
    assign clr[0] = clr_any & match[i][0];
    assign clr[1] = clr_any & ~match[i][0];
    for (genvar j = 0; j < SLOTS; j++)
    begin : g_slot
      wire [STAMP_W-1:0] age = stamp_q - slot_q[j].stamp;
      assign ex[j] = slot_q[j].v & ~slot_q[j].sel &
                     (age > {1'b0, lat_win});
      assign mk[j] = trig_ok & slot_q[j].v &
                     (slot_q[j].stamp == trig_i.stamp);
      assign match[i][j] = tq_vld & slot_q[j].v & slot_q[j].sel &
                           (slot_q[j].stamp == head);
    end
    assign m_amp[i] = match[i][0] ? slot_q[0].amp : slot_q[1].amp;

    always_ff @(posedge sys_clk_i)
    begin
      if (srst_i)
      begin
        s_q   <= '0;
        lvl_q <= 1'b0;
        cnt_q <= '0;
        st_q  <= '0;
        for (int j = 0; j < SLOTS; j++)
          slot_q[j] <= '0;
      end
      else
      begin
        s_q   <= {s_q[1:0], disc_i[i]};
        lvl_q <= lvl_n;
        if (lvl_n & ~lvl_q)
        begin
          cnt_q <= 4'h1;
          st_q  <= stamp_q;
        end
        else if (lvl_q & (cnt_q != 4'hf))
          cnt_q <= cnt_q + 4'h1;
        for (int j = 0; j < SLOTS; j++)
          if (wr[j])
            slot_q[j] <= '{v: 1'b1, sel: 1'b0, stamp: st_q,
                           amp: cnt_q};
          else if (clr[j] | ex[j])
            slot_q[j] <= '0;
          else if (mk[j])
            slot_q[j].sel <= 1'b1;
      end
    end
  end

  // Section sparsifiers and FIFOs
  logic [NUM_SECT-1:0] f_vld, f_rdy, f_in_rdy;
  ssr_hit_s            f_data [NUM_SECT];

  for (genvar s = 0; s < NUM_SECT; s++)
  begin : g_sect
    ssr_hit_s w;
    always_comb
    begin
      sreq[s] = 1'b0;
      gidx[s] = '0;
      for (int k = SECT_STRIPS - 1; k >= 0; k--)
        if (|match[s*SECT_STRIPS + k])
        begin
          sreq[s] = 1'b1;
          gidx[s] = SECT_W'(k);
        end
    end
    assign spush[s] = sreq[s] & f_in_rdy[s];
    always_comb
    begin
      w       = '0;
      w.strip = STRIP_W'(s*SECT_STRIPS) + STRIP_W'(gidx[s]);
      w.stamp = head;
      w.valid = 1'b1;
      w.chip  = chip_id;
      w.amp   = m_amp[s*SECT_STRIPS + int'(gidx[s])];
      w.spare = '0;
    end
    ssr_fifo #(.W(HIT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk_i  (sys_clk_i),
      .srst_i     (srst_i),
      .in_vld_i   (sreq[s]),
      .in_rdy_o   (f_in_rdy[s]),
      .in_data_i  (w),
      .out_vld_o  (f_vld[s]),
      .out_rdy_i  (f_rdy[s]),
      .out_data_o (f_data[s])
    );
  end

  // Concentrator picks the oldest head stamp
  logic [1:0]         csel;
  logic [STAMP_W-1:0] cage;
  always_comb
  begin
    csel = '0;
    cage = '0;
    for (int s = 0; s < NUM_SECT; s++)
      if (f_vld[s] && (STAMP_W'(stamp_q - f_data[s].stamp) >= cage))
      begin
        csel = 2'(s);
        cage = stamp_q - f_data[s].stamp;
      end
  end

  // Merged output stage
  logic [SER_BITS-1:0] osh_q;
  logic [4:0]          left_q, beats;
  logic [3:0]          odiv_q;
  logic                first_q;
  wire                 busy = (left_q != 5'h0);
  wire                 ld   = ~busy & |f_vld;
  wire                 tick = (odiv_q == bit_div);
  logic [3:0]          lane_bits;
  assign f_rdy = ld ? (NUM_SECT'(1) << csel) : '0;

  always_comb
  begin
    case (lanes_m1)
      2'h0: beats = 5'(SER_BITS);
      2'h1: beats = 5'((SER_BITS + 1) / 2);
      2'h2: beats = 5'((SER_BITS + 2) / 3);
      2'h3: beats = 5'((SER_BITS + 3) / 4);
      default: beats = 5'(SER_BITS);
    endcase
    for (int k = 0; k < 4; k++)
      lane_bits[k] = (2'(k) <= lanes_m1) & osh_q[SER_BITS-1-k];
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      osh_q   <= '0;
      left_q  <= '0;
      odiv_q  <= '0;
      first_q <= 1'b0;
      ser_o   <= '0;
    end
    else
    begin
      odiv_q       <= tick ? 4'h0 : odiv_q + 4'h1;
      ser_o.strobe <= 1'b0;
      ser_o.frame  <= 1'b0; // Frame marks one beat only
      if (ld)
      begin
        osh_q   <= {f_data[csel], 1'b0};
        left_q  <= beats;
        first_q <= 1'b1;
      end
      else if (busy & tick)
      begin
        ser_o.data   <= lane_bits;
        ser_o.frame  <= first_q;
        ser_o.strobe <= 1'b1;
        first_q      <= 1'b0;
        osh_q        <= osh_q << (lanes_m1 + 3'h1);
        left_q       <= left_q - 5'h1;
      end
    end
  end
endmodule // ssr_readout

// ==== dv/ssr_readout_properties.sv ====
// Port checks for the strip readout
`timescale 1ns/10ps
module ssr_readout_props (
  input wire logic                            sys_clk_i,
  input wire logic                            srst_i,
  input wire logic [ssr_pkg::NUM_STRIPS-1:0]  disc_i,
  input wire ssr_pkg::ssr_trig_s              trig_i,
  input wire ssr_pkg::ssr_cfg_in_s            cfg_i,
  input wire logic                            cfg_sdo_o,
  input wire logic [ssr_pkg::NUM_BIAS*8-1:0]  bias_dac_o,
  input wire logic [7:0]                      inject_sel_o,
  input wire ssr_pkg::ssr_ser_s               ser_o,
  input wire logic                            trig_drop_o
);
  import ssr_pkg::*;
  logic seen_q;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // Cleared by reset so a word before any trigger is caught
  always_ff @(posedge sys_clk_i)
    seen_q <= srst_i ? 1'b0 : (seen_q | trig_i.vld);
  reset_vals_a: assert property ($past(srst_i) |->
    bias_dac_o == {NUM_BIAS{BIAS_RST}} && inject_sel_o == INJ_RST
    && ser_o == '0 && !trig_drop_o) else $error("bad reset outputs");
  frame_strobe_a: assert property (ser_o.frame |-> ser_o.strobe)
    else $error("frame without strobe");
  frame_gap_a: assert property (ser_o.frame |=>
    (!ser_o.frame) [*6]) else $error("word too short");
  drop_cause_a: assert property (trig_drop_o |-> $past(trig_i.vld))
    else $error("drop without trigger");
  cfg_idle_a: assert property (cfg_i.csn [*6] |=>
    $stable(bias_dac_o) && $stable(inject_sel_o))
    else $error("register changed while deselected");
  sdo_idle_a: assert property (cfg_i.csn [*6] |=>
    $stable(cfg_sdo_o)) else $error("readback moved while deselected");
  sclk_idle_a: assert property (($stable(cfg_i.sclk)) [*6] |=>
    $stable(bias_dac_o)) else $error("bias changed without clock");
  trig_before_a: assert property (ser_o.frame |-> seen_q)
    else $error("word before any trigger");
  cover property (ser_o.frame);
  cover property (trig_drop_o);
  cover property ($changed(bias_dac_o));
endmodule // ssr_readout_props

bind ssr_readout ssr_readout_props u_props (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .disc_i(disc_i),
  .trig_i(trig_i), .cfg_i(cfg_i), .cfg_sdo_o(cfg_sdo_o),
  .bias_dac_o(bias_dac_o), .inject_sel_o(inject_sel_o),
  .ser_o(ser_o), .trig_drop_o(trig_drop_o)
);

// ==== dv/ssr_daq_rx.sv ====
// Receiver model that rebuilds words from the serial lanes
`timescale 1ns/10ps
module ssr_daq_rx (
  input  wire logic              sys_clk_i,
  input  wire logic              srst_i,
  input  wire ssr_pkg::ssr_ser_s ser_i,
  input  wire logic [2:0]        lanes_i,
  output logic                   vld_o,
  output logic [27:0]            word_o
);
  import ssr_pkg::*;
  logic [27:0] sh_q;
  int          cnt_q;
  always @(posedge sys_clk_i)
  begin : rx
    int          b;
    logic [27:0] w;
    logic        done;
    done = 1'b0;
    if (srst_i)
      cnt_q <= 0;
    else if (ser_i.strobe)
    begin
      b = ser_i.frame ? 0 : cnt_q;
      w = ser_i.frame ? '0 : sh_q;
      // Lane k carries the k-th bit of each beat group, MSB first
      for (int k = 0; k < lanes_i; k++)
        if (b + k < 28) w[27 - b - k] = ser_i.data[k];
      sh_q  <= w;
      cnt_q <= b + lanes_i;
      done  = (b + lanes_i >= 28);
      if (done)
        word_o <= w;
    end
    vld_o <= done;
  end
endmodule // ssr_daq_rx

// ==== dv/tb_strip_readout_sparsifier.sv ====
// Testbench for the strip readout
`timescale 1ns/10ps
module tb_strip_readout_sparsifier;
  import ssr_pkg::*;
  logic                  sys_clk_i = 1'b0;
  logic                  srst_i = 1'b1;
  logic [NUM_STRIPS-1:0] disc_i = '0;
  ssr_trig_s             trig_i = '0;
  ssr_cfg_in_s           cfg_i = 3'b100;
  logic                  cfg_sdo_o, trig_drop_o, rx_vld;
  logic [31:0]           bias_dac_o;
  logic [7:0]            inject_sel_o, q;
  ssr_ser_s              ser_o;
  logic [27:0]           rx_word;
  logic [2:0]            lanes = 3'd4;
  logic [27:0]           rx_q[$];
  ssr_hit_s              w;
  int cyc, err_count, total_checks, drops, off, t, u;
  int ord[5] = '{100, 70, 40, 3, 5};

  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    cyc <= srst_i ? 0 : cyc + 1;
    if (rx_vld === 1'b1) rx_q.push_back(rx_word);
    if (trig_drop_o === 1'b1) drops++;
  end

  ssr_readout dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .disc_i(disc_i), .trig_i(trig_i), .cfg_i(cfg_i),
    .cfg_sdo_o(cfg_sdo_o), .bias_dac_o(bias_dac_o),
    .inject_sel_o(inject_sel_o), .ser_o(ser_o),
    .trig_drop_o(trig_drop_o));
  ssr_daq_rx rx (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ser_i(ser_o),
    .lanes_i(lanes), .vld_o(rx_vld), .word_o(rx_word));

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  function automatic logic [27:0] mk(input int s, input int tt, input int a);
    ssr_hit_s h;
    h = '0;
    h.chip = 4'h9;
    h.amp = a[3:0];
    h.valid = 1'b1;
    h.stamp = 9'(tt + off);
    h.strip = s[6:0];
    return {h, 1'b0};
  endfunction

  // Sclk levels held 6 cycles, well past the input filter
  task automatic cfg(input logic rd, input logic [4:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {rd, 2'b00, a, d};
    cfg_i.csn <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      cfg_i.sdi <= f[i];
      tick(6);
      if (i < 8) q[i] = cfg_sdo_o;
      cfg_i.sclk <= 1'b1;
      tick(6);
      cfg_i.sclk <= 1'b0;
    end
    tick(6);
    cfg_i.csn <= 1'b1;
    tick(6);
  endtask

  task automatic hit(input logic [NUM_STRIPS-1:0] m, input int h);
    disc_i <= disc_i | m;
    t = cyc;
    tick(h);
    disc_i <= disc_i & ~m;
    tick(6);
  endtask

  task automatic trg(input int tt);
    trig_i <= {1'b1, 9'(tt + off)};
    tick(1);
    trig_i.vld <= 1'b0;
    tick(1);
  endtask

  task automatic expect_w(input logic [27:0] e);
    for (int i = 0; i < 600 && rx_q.size() == 0; i++) tick(1);
    chk(rx_q.size() > 0 ? rx_q.pop_front() : 28'hfffffff, e);
  endtask

  task automatic finish_test;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    tick(30000);
    err_count++;
    finish_test();
  end

  initial
  begin
    tick(4);
    srst_i <= 1'b0;
    tick(1);
    chk(bias_dac_o, 32'h80808080);
    chk(inject_sel_o, 8'h00);
    cfg(0, 5'd1, 8'h5a);
    cfg(0, 5'd5, 8'hc3);
    cfg(0, 5'd6, 8'h09);
    chk(bias_dac_o, 32'h80805a80);
    cfg(1, 5'd5, 8'h00);
    chk(q, 8'hc3);
    cfg(1, 5'd7, 8'h00);
    chk(q, 8'he9);
    chk(inject_sel_o, 8'hc3);
    // Stamp origin is a design latency: sweep, only one may match
    hit(128'h1 << 10, 5);
    for (int k = 0; k < 10; k++)
    begin
      trg(t + k);
      tick(1);
    end
    tick(80);
    chk(rx_q.size(), 1);
    if (rx_q.size() > 0)
    begin
      w = rx_q[0][27:1];
      off = int'(w.stamp) - t;
    end
    expect_w(mk(10, t, 5));
    hit(128'h1 << 20, 3);
    hit((128'h1 << 3) | (128'h1 << 5) | (128'h1 << 40) |
        (128'h1 << 70) | (128'h1 << 100), 4);
    trg(t);
    foreach (ord[i]) expect_w(mk(ord[i], t, 4));
    tick(60);
    chk(rx_q.size(), 0);
    hit(128'h1 << 8, 3);
    u = t;
    hit((128'h1 << 8) | (128'h1 << 90), 3);
    trg(u);
    trg(t);
    expect_w(mk(8, u, 3));
    expect_w(mk(90, t, 3));
    expect_w(mk(8, t, 3));
    cfg(0, 5'd17, 8'h10);
    hit((128'h1 << 12) | (128'h1 << 13), 3);
    trg(t);
    expect_w(mk(13, t, 3));
    tick(40);
    chk(rx_q.size(), 0);
    // Full section stalls its FIFO, so the trigger queue fills
    drops = 0;
    hit(128'hffffffff, 20);
    trg(t);
    for (int k = 0; k < 5; k++) trg(t + 200);
    tick(2);
    chk(drops, 2);
    // Strip 12 is still masked, so it yields no word
    for (int i = 0; i < 32; i++)
      if (i != 12) expect_w(mk(i, t, 15));
    cfg(0, 5'd7, 8'h30);
    hit(128'h1 << 50, 3);
    hit(128'h1 << 50, 3);
    tick(80);
    trg(t);
    tick(40);
    chk(rx_q.size(), 0);
    hit(128'h1 << 50, 3);
    u = t;
    hit(128'h1 << 50, 3);
    trg(u);
    trg(t);
    expect_w(mk(50, u, 3));
    expect_w(mk(50, t, 3));
    for (int l = 0; l < 3; l++)
    begin
      cfg(0, 5'd4, 8'h04 | 8'(l));
      lanes <= 3'(l + 1);
      hit(128'h1 << (120 + l), 3);
      trg(t);
      expect_w(mk(120 + l, t, 3));
    end
    finish_test();
  end
endmodule // tb_strip_readout_sparsifier
